// file: pkg/margin_ctl_regs.vh
// Constants for the supply margin, trim and monitor controller.
// Assumes inclusion by bare name from verilog/ design files.
`ifndef MARGIN_CTL_REGS_VH
`define MARGIN_CTL_REGS_VH
`define ADC_W           10
`define TRIM_W          10
`define TRIM_MID        10'h200
`define NVM_AW          8
`define NVM_DEPTH       256
`define FILT_W          8
`define STEP_DIV_W      4
`define STEP_DIV        4'hF
`define ADDR_BASE       7'h40
`define ADDR_LAST       5'h14
`define PIN_RST         7'h40
`define ST_IDLE         2'h0
`define ST_SEEK         2'h1
`define ST_HOLD         2'h2
`define DIR_NONE        2'h0
`define DIR_UP          2'h1
`define DIR_DOWN        2'h2
`define STAT_W          8
`endif

// file: verilog/sense_glitch_filter.v
// Glitch filter for one comparator fault input.
// Assumes the input is already synchronised to mclk_in.
`include "margin_ctl_regs.vh"
module sense_glitch_filter (
  // Clock and control.
  input  wire                 mclk_in,
  input  wire                 srst_in,
  input  wire                 ce_in,
  // Filter.
  input  wire                 raw_in,
  input  wire [`FILT_W-1:0]   len_in,
  output wire                 filt_out
);
  reg [`FILT_W-1:0] cnt_ff;
  reg               out_ff;
  // Output changes only after the raw level held longer than len_in cycles.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_ff <= {`FILT_W{1'b0}};
      out_ff <= 1'b0;
    end else if (ce_in) begin
      if (raw_in == out_ff) begin
        cnt_ff <= {`FILT_W{1'b0}};
      end else if (cnt_ff >= len_in) begin
        out_ff <= raw_in;
        cnt_ff <= {`FILT_W{1'b0}};
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
  assign filt_out = out_ff;
endmodule // sense_glitch_filter

// file: verilog/supply_margin_trim_monitor.v
// Margin controller, supply monitor, fault comparators and general memory.
// Assumes a host-side bus decoder drives the config and access ports on mclk_in.
`include "margin_ctl_regs.vh"
// Contract
// - Host programs high and low targets; up seeks high, down seeks low.
// - Margining starts on a request pin or a host margin command.
// - While margining, trim counter steps by comparing target with ADC reading.
// - Stepping repeats until equal, then counter freezes and trim holds.
// - Host release, or in pin mode a request pin drop, returns trim to high impedance.
// - Trim output stays high impedance whenever not margining.
// - Monitored voltage 10-bit conversion result is readable by host.
// - Each comparator input independently selects undervoltage or overvoltage.
// - A setting picks the comparator reference as 0.5 V or 1.25 V.
// - Each comparator input filters out faults no longer than programmed length.
// - Fault output pulls low while either comparator input is in fault.
// - Option suppresses the fault output while margining.
// - Write-protect has programmable polarity and blocks config and memory writes.
// - A 256-byte general memory is host readable and writable.
// - Three tri-level address pins give 21 distinct bus addresses.
// - Host can read a status word showing device state.
// - Ready shows set point reached; pulled low when active high latches comparators.
module supply_margin_trim_monitor (
  // Clock and control.
  input  wire                  mclk_in,
  input  wire                  srst_in,
  input  wire                  ce_in,
  // Request pins and protect pin.
  input  wire                  margin_raise_req_in,
  input  wire                  margin_lower_req_in,
  input  wire                  wp_pin_in,
  // Tri-level address pins: high and float senses per pin.
  input  wire [2:0]            addr_pin_high_in,
  input  wire [2:0]            addr_pin_float_in,
  // Converter, comparator and ready pin inputs.
  input  wire [`ADC_W-1:0]     adc_data_in,
  input  wire                  adc_valid_in,
  input  wire                  cmp_a_above_in,
  input  wire                  cmp_b_above_in,
  input  wire                  ready_pin_in,
  // Host configuration writes.
  input  wire                  cfg_we_in,
  input  wire [`ADC_W-1:0]     cfg_target_high_in,
  input  wire [`ADC_W-1:0]     cfg_target_low_in,
  input  wire [1:0]            cfg_ov_sel_in,
  input  wire                  cfg_vref_high_in,
  input  wire [`FILT_W-1:0]    cfg_filt_len_in,
  input  wire                  cfg_fault_mask_in,
  input  wire                  cfg_ready_pol_in,
  input  wire                  cfg_wp_pol_in,
  // Host margin commands.
  input  wire                  cmd_margin_up_in,
  input  wire                  cmd_margin_down_in,
  input  wire                  cmd_release_in,
  // Host memory access.
  input  wire                  nvm_we_in,
  input  wire [`NVM_AW-1:0]    nvm_addr_in,
  input  wire [7:0]            nvm_wdata_in,
  output wire [7:0]            nvm_rdata_out,
  // Host readback.
  output wire [`ADC_W-1:0]     adc_result_out,
  output wire [`STAT_W-1:0]    status_out,
  output wire                  write_rejected_out,
  output wire [6:0]            bus_addr_out,
  output wire                  vref_sel_out,
  // Trim and open-drain pins.
  output wire [`TRIM_W-1:0]    trim_level_out,
  output wire                  trim_oe_out,
  output wire                  fault_out,
  output wire                  fault_oe_out,
  output wire                  ready_out,
  output wire                  ready_oe_out
);
  reg  [2:0]            s1_ff, s2_ff;
  reg  [1:0]            c1_ff, c2_ff;
  reg  [6:0]            p1_ff, p2_ff;
  reg  [`ADC_W-1:0]     tgt_hi_ff, tgt_lo_ff, adc_ff;
  reg  [1:0]            ov_sel_ff;
  reg                   vref_ff, fmask_ff, rpol_ff, wpol_ff;
  reg  [`FILT_W-1:0]    flen_ff;
  reg  [1:0]            state_ff, nxt_state;
  reg  [1:0]            dir_ff, nxt_dir;
  reg                   pin_mode_ff, nxt_pin_mode;
  reg  [`TRIM_W-1:0]    trim_ff;
  reg  [`STEP_DIV_W-1:0] div_ff;
  reg                   adc_new_ff;
  reg  [7:0]            mem_ff [0:`NVM_DEPTH-1];
  reg  [7:0]            rd_ff;
  reg  [1:0]            latch_ff;
  reg                   rej_ff;
  reg  [6:0]            addr_ff;
  wire                  raise_pin, lower_pin, wp_act, cfg_ok, ready_low;
  wire [1:0]            raw_fault, filt_fault;
  wire [`ADC_W-1:0]     target;
  wire                  margining;
  wire                  ready_sync;
  wire [5:0]            pin_lvl;
  wire [4:0]            addr_idx;
  // Margin states.
  localparam [1:0]      S_IDLE = `ST_IDLE;
  localparam [1:0]      S_SEEK = `ST_SEEK;
  localparam [1:0]      S_HOLD = `ST_HOLD;
  // Synchronise pins.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      c1_ff <= 2'h0;
      c2_ff <= 2'h0;
    end else if (ce_in) begin
      s1_ff <= {wp_pin_in, margin_lower_req_in, margin_raise_req_in};
      s2_ff <= s1_ff;
      c1_ff <= {cmp_b_above_in, cmp_a_above_in};
      c2_ff <= c1_ff;
    end
  end
  assign raise_pin = s2_ff[0] & ~s2_ff[1];
  assign lower_pin = s2_ff[1] & ~s2_ff[0];
  assign wp_act    = (s2_ff[2] == wpol_ff);
  assign cfg_ok    = ~wp_act;
  // Synchronise address and ready pins; ready idles high behind its pull-up.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      p1_ff <= `PIN_RST;
      p2_ff <= `PIN_RST;
    end else if (ce_in) begin
      p1_ff <= {ready_pin_in, addr_pin_float_in, addr_pin_high_in};
      p2_ff <= p1_ff;
    end
  end
  assign ready_sync = p2_ff[6];
  // Configuration registers.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      tgt_hi_ff <= {`ADC_W{1'b0}};
      tgt_lo_ff <= {`ADC_W{1'b0}};
      ov_sel_ff <= 2'h0;
      vref_ff   <= 1'b0;
      flen_ff   <= {`FILT_W{1'b0}};
      fmask_ff  <= 1'b0;
      rpol_ff   <= 1'b1;
      wpol_ff   <= 1'b1;
      rej_ff    <= 1'b0;
    end else if (ce_in) begin
      rej_ff <= (cfg_we_in | nvm_we_in) & wp_act;
      if (cfg_we_in && cfg_ok) begin
        tgt_hi_ff <= cfg_target_high_in;
        tgt_lo_ff <= cfg_target_low_in;
        ov_sel_ff <= cfg_ov_sel_in;
        vref_ff   <= cfg_vref_high_in;
        flen_ff   <= cfg_filt_len_in;
        fmask_ff  <= cfg_fault_mask_in;
        rpol_ff   <= cfg_ready_pol_in;
        wpol_ff   <= cfg_wp_pol_in;
      end
    end
  end
  // General memory.
  always @(posedge mclk_in) begin
    if (ce_in) begin
      if (nvm_we_in && cfg_ok) begin
        mem_ff[nvm_addr_in] <= nvm_wdata_in;
      end
      rd_ff <= mem_ff[nvm_addr_in];
    end
  end
  // ADC capture.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      adc_ff     <= {`ADC_W{1'b0}};
      adc_new_ff <= 1'b0;
    end else if (ce_in) begin
      if (adc_valid_in) begin
        adc_ff <= adc_data_in;
      end
      adc_new_ff <= adc_valid_in;
    end
  end
  // Margin state machine.
  assign target = (dir_ff == `DIR_UP) ? tgt_hi_ff : tgt_lo_ff;
  always @* begin
    nxt_state    = state_ff;
    nxt_dir      = dir_ff;
    nxt_pin_mode = pin_mode_ff;
    case (state_ff)
      S_IDLE: begin
        if (cmd_margin_up_in | raise_pin) begin
          nxt_state    = S_SEEK;
          nxt_dir      = `DIR_UP;
          nxt_pin_mode = ~cmd_margin_up_in;
        end else if (cmd_margin_down_in | lower_pin) begin
          nxt_state    = S_SEEK;
          nxt_dir      = `DIR_DOWN;
          nxt_pin_mode = ~cmd_margin_down_in;
        end
      end
      // Only a host release or, in pin mode, a drop of the starting request pin or a rise of the other one is heard once margining has started.
      S_SEEK, S_HOLD: begin
        if (adc_new_ff && adc_ff == target) begin
          nxt_state = S_HOLD;
        end
        if (cmd_release_in ||
            (pin_mode_ff && dir_ff == `DIR_UP && !raise_pin) ||
            (pin_mode_ff && dir_ff == `DIR_DOWN && !lower_pin)) begin
          nxt_state = S_IDLE;
          nxt_dir   = `DIR_NONE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_dir   = `DIR_NONE;
      end
    endcase
  end
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff    <= S_IDLE;
      dir_ff      <= `DIR_NONE;
      pin_mode_ff <= 1'b0;
      trim_ff     <= `TRIM_MID;
      div_ff      <= {`STEP_DIV_W{1'b0}};
    end else if (ce_in) begin
      state_ff    <= nxt_state;
      dir_ff      <= nxt_dir;
      pin_mode_ff <= nxt_pin_mode;
      if (state_ff == S_IDLE) begin
        trim_ff <= `TRIM_MID;
        div_ff  <= {`STEP_DIV_W{1'b0}};
      end else if (state_ff == S_SEEK && nxt_state == S_SEEK && adc_new_ff) begin
        div_ff <= div_ff + 1'b1;
        if (div_ff == `STEP_DIV) begin
          if (adc_ff < target && trim_ff != {`TRIM_W{1'b1}}) begin
            trim_ff <= trim_ff + 1'b1;
          end else if (adc_ff > target && trim_ff != {`TRIM_W{1'b0}}) begin
            trim_ff <= trim_ff - 1'b1;
          end
        end
      end
    end
  end
  assign margining      = (state_ff != S_IDLE);
  assign trim_level_out = trim_ff;
  assign trim_oe_out    = margining;
  // Comparators and fault output.
  // A fault is the comparator level that matches its selected direction.
  assign raw_fault = c2_ff ~^ ov_sel_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      sense_glitch_filter u_filt (
        .mclk_in  (mclk_in),
        .srst_in  (srst_in),
        .ce_in    (ce_in),
        .raw_in   (raw_fault[gi]),
        .len_in   (flen_ff),
        .filt_out (filt_fault[gi])
      );
    end
  endgenerate
  // The fault pin is open drain: only its enable moves.
  assign fault_out    = 1'b0;
  assign fault_oe_out = (|filt_fault) & ~(fmask_ff & margining);
  // Ready output and comparator latch.
  // Latch only when something outside pulls ready low, not on our own drive.
  assign ready_low = rpol_ff & ~ready_sync & ~ready_oe_out;
  always @(posedge mclk_in) begin
    if (srst_in) begin
      latch_ff <= 2'h0;
    end else if (ce_in && !ready_low) begin
      latch_ff <= filt_fault;
    end
  end
  assign ready_out    = 1'b0;
  assign ready_oe_out = rpol_ff ? (state_ff != S_HOLD) : (state_ff == S_HOLD);
  // Bus address from tri-level pins: low 0, high 1, float 2 per pin.
  genvar ai;
  generate
    for (ai = 0; ai < 3; ai = ai + 1) begin : g_addr
      assign pin_lvl[ai*2 +: 2] = p2_ff[3+ai] ? 2'h2 : {1'b0, p2_ff[ai]};
    end
  endgenerate
  assign addr_idx = {3'h0, pin_lvl[5:4]} * 5'h9 +
                    {3'h0, pin_lvl[3:2]} * 5'h3 +
                    {3'h0, pin_lvl[1:0]};
  // Codes past the last one fold onto it, so the pins name 21 addresses.
  always @(posedge mclk_in) begin
    if (srst_in) begin
      addr_ff <= `ADDR_BASE;
    end else if (ce_in) begin
      addr_ff <= `ADDR_BASE + {2'h0, (addr_idx > `ADDR_LAST) ? `ADDR_LAST : addr_idx};
    end
  end
  assign bus_addr_out       = addr_ff;
  assign vref_sel_out       = vref_ff;
  assign nvm_rdata_out      = rd_ff;
  assign adc_result_out     = adc_ff;
  assign write_rejected_out = rej_ff;
  assign status_out = {wp_act, latch_ff, filt_fault, pin_mode_ff, state_ff};
endmodule // supply_margin_trim_monitor

// file: verification/margin_ctl_checker.sv
// Port assertions for the margin controller.
// Assumes binding onto every supply_margin_trim_monitor instance.
`include "margin_ctl_regs.vh"
module margin_ctl_checker (
  input logic                 mclk_in,
  input logic                 srst_in,
  input logic                 ce_in,
  input logic                 cmd_margin_up_in,
  input logic                 cmd_release_in,
  input logic                 cfg_we_in,
  input logic                 nvm_we_in,
  input logic                 adc_valid_in,
  input logic [`TRIM_W-1:0]   trim_level_out,
  input logic                 trim_oe_out,
  input logic                 fault_oe_out,
  input logic [`STAT_W-1:0]   status_out,
  input logic                 write_rejected_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  wire [1:0] st = status_out[1:0];
  property p_idle; st == `ST_IDLE |-> !trim_oe_out; endproperty
  a_idle: assert property (p_idle) else $error("trim driven while idle");
  property p_start; ce_in && st == `ST_IDLE && cmd_margin_up_in |=> trim_oe_out; endproperty
  a_start: assert property (p_start) else $error("margin command not taken");
  property p_rel; ce_in && trim_oe_out && cmd_release_in |=> !trim_oe_out; endproperty
  a_rel: assert property (p_rel) else $error("release not taken");
  property p_step;
    trim_oe_out && $past(trim_oe_out) |-> trim_level_out == $past(trim_level_out) ||
      trim_level_out == $past(trim_level_out) + 10'h1 ||
      trim_level_out + 10'h1 == $past(trim_level_out);
  endproperty
  a_step: assert property (p_step) else $error("trim moved more than one step");
  property p_frz; st == `ST_HOLD && $past(st) == `ST_HOLD |-> $stable(trim_level_out); endproperty
  a_frz: assert property (p_frz) else $error("trim moved in hold");
  property p_hold;
    st == `ST_HOLD && $past(st) == `ST_SEEK |-> $past(adc_valid_in) || $past(adc_valid_in, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("hold without a sample");
  property p_seek; $rose(trim_oe_out) |-> st == `ST_SEEK; endproperty
  a_seek: assert property (p_seek) else $error("trim driven outside seek");
  property p_rej; write_rejected_out |-> $past(cfg_we_in || nvm_we_in); endproperty
  a_rej: assert property (p_rej) else $error("reject without a write");
  property p_rst; disable iff (1'b0) srst_in |=> !trim_oe_out && !fault_oe_out; endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
endmodule // margin_ctl_checker
bind supply_margin_trim_monitor margin_ctl_checker u_chk (.mclk_in(mclk_in), .srst_in(srst_in),
  .ce_in(ce_in), .cmd_margin_up_in(cmd_margin_up_in), .cmd_release_in(cmd_release_in),
  .cfg_we_in(cfg_we_in), .nvm_we_in(nvm_we_in), .adc_valid_in(adc_valid_in),
  .trim_level_out(trim_level_out), .trim_oe_out(trim_oe_out), .fault_oe_out(fault_oe_out),
  .status_out(status_out), .write_rejected_out(write_rejected_out));

// file: verification/trim_converter_model.sv
// Converter and monitor converter model facing the trim pin.
// Assumes one trim code moves the reading by one code.
`include "margin_ctl_regs.vh"
module trim_converter_model (
  input  logic                mclk_in,
  input  logic                slow_in,
  input  logic [`TRIM_W-1:0]  trim_level_out,
  input  logic                trim_oe_out,
  output logic [`ADC_W-1:0]   adc_data_in,
  output logic                adc_valid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div = 3'h0;
  initial adc_data_in = `TRIM_MID;
  initial adc_valid_in = 1'b0;
  // Nominal reading while released, trim code otherwise.
  always @(posedge mclk_in) begin
    div <= div + 3'h1;
    adc_valid_in <= slow_in ? (div == 3'h0) : div[0];
    adc_data_in <= trim_oe_out ? trim_level_out : `TRIM_MID;
  end
endmodule // trim_converter_model

// file: verification/supply_margin_trim_monitor_tb_top.sv
// Self-checking bench for the margin controller.
// Assumes the design, checker and converter model are compiled first.
`include "margin_ctl_regs.vh"
module supply_margin_trim_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0, srst_in = 1'b1, up_req = 1'b0, dn_req = 1'b0, wp = 1'b0, slow = 1'b0;
  logic cfg_we = 1'b0, cfg_vh = 1'b0, cmd_up = 1'b0, cmd_rel = 1'b0, nvm_we = 1'b0;
  logic cmp_a = 1'b0, cmp_b = 1'b1, cmd_dn = 1'b0, fmask = 1'b0;
  logic [2:0] a_hi = 3'h0, a_fl = 3'h0;
  logic [9:0] t_hi = 10'h200, t_lo = 10'h200;
  logic [1:0] ov = 2'h0;
  logic [7:0] flen = 8'h0, naddr = 8'h0, nwd = 8'h0;
  wire [9:0] adc_d, trim, adc_r;
  wire [7:0] nrd, stat;
  wire [6:0] baddr;
  wire adc_v, trim_oe, fault_oe, rej, vsel, ready_oe;
  logic [19:0] q[$];
  int n_fail = 0, n_tests = 0, cyc = 0, n_rej = 0;
  initial forever #2.5 mclk_in = ~mclk_in;
  supply_margin_trim_monitor u_dut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1),
    .margin_raise_req_in(up_req), .margin_lower_req_in(dn_req), .wp_pin_in(wp),
    .addr_pin_high_in(a_hi), .addr_pin_float_in(a_fl), .adc_data_in(adc_d), .adc_valid_in(adc_v),
    .cmp_a_above_in(cmp_a), .cmp_b_above_in(cmp_b), .ready_pin_in(1'b1), .cfg_we_in(cfg_we),
    .cfg_target_high_in(t_hi), .cfg_target_low_in(t_lo), .cfg_ov_sel_in(ov),
    .cfg_vref_high_in(cfg_vh), .cfg_filt_len_in(flen), .cfg_fault_mask_in(fmask),
    .cfg_ready_pol_in(1'b0), .cfg_wp_pol_in(1'b1), .cmd_margin_up_in(cmd_up),
    .cmd_margin_down_in(cmd_dn), .cmd_release_in(cmd_rel), .nvm_we_in(nvm_we),
    .nvm_addr_in(naddr), .nvm_wdata_in(nwd), .nvm_rdata_out(nrd), .adc_result_out(adc_r),
    .status_out(stat), .write_rejected_out(rej), .bus_addr_out(baddr), .vref_sel_out(vsel),
    .trim_level_out(trim), .trim_oe_out(trim_oe), .fault_out(), .fault_oe_out(fault_oe),
    .ready_out(), .ready_oe_out(ready_oe));
  trim_converter_model u_conv (.mclk_in(mclk_in), .slow_in(slow), .trim_level_out(trim),
    .trim_oe_out(trim_oe), .adc_data_in(adc_d), .adc_valid_in(adc_v));
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = {15'h0, trim_oe};
      4'h1: obs = {6'h0, trim};
      4'h2: obs = {6'h0, adc_r};
      4'h3: obs = {9'h0, baddr};
      4'h4: obs = {15'h0, vsel};
      4'h5: obs = {15'h0, fault_oe};
      4'h6: obs = {8'h0, nrd};
      4'h7: obs = 16'(n_rej);
      4'h8: obs = {15'h0, ready_oe};
      default: obs = {8'h0, stat};
    endcase
  endfunction
  task automatic cmp_val(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic expect_v(input logic [3:0] s, input logic [15:0] v);
    q.push_back({s, v});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 1000 && stat[1:0] !== s; i++) tick(1);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Monitor takes every queued note, oldest first, once outputs have settled.
  always @(negedge mclk_in) begin
    while (q.size() != 0) begin
      cmp_val(q[0][15:0], obs(q[0][19:16]));
      void'(q.pop_front());
    end
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (rej) n_rej <= n_rej + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    logic [1:0] l0, l1, l2;
    logic [7:0] d;
    int idx;
    void'($urandom(32'h4E87D458));
    tick(2);
    srst_in = 1'b0;
    for (int i = 0; i < 6; i++) begin
      l0 = 2'($urandom_range(2));
      l1 = 2'($urandom_range(2));
      l2 = 2'($urandom_range(2));
      a_hi = {l2 == 2'h1, l1 == 2'h1, l0 == 2'h1};
      a_fl = {l2 == 2'h2, l1 == 2'h2, l0 == 2'h2};
      tick(3);
      idx = 9 * l2 + 3 * l1 + l0;
      expect_v(4'h3, 16'(`ADDR_BASE + (idx > `ADDR_LAST ? `ADDR_LAST : idx)));
      expect_v(4'h0, 16'h0);
    end
    t_hi = 10'(10'h200 + $urandom_range(4, 1));
    t_lo = 10'(10'h200 - $urandom_range(4, 1));
    ov = 2'h1;
    cfg_vh = 1'b1;
    flen = 8'h03;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(2);
    expect_v(4'h4, 16'h1);
    cmd_up = 1'b1;
    tick(1);
    cmd_up = 1'b0;
    expect_v(4'h0, 16'h1);
    wait_st(`ST_HOLD);
    tick(4);
    expect_v(4'h1, {6'h0, t_hi});
    expect_v(4'h2, {6'h0, t_hi});
    cmd_rel = 1'b1;
    tick(1);
    cmd_rel = 1'b0;
    expect_v(4'h0, 16'h0);
    slow = 1'b1;
    dn_req = 1'b1;
    tick(4);
    wait_st(`ST_HOLD);
    tick(12);
    expect_v(4'h1, {6'h0, t_lo});
    expect_v(4'h8, 16'h1);
    expect_v(4'h9, {8'h0, 5'h0, 1'b1, `ST_HOLD});
    dn_req = 1'b0;
    tick(6);
    expect_v(4'h0, 16'h0);
    expect_v(4'h8, 16'h0);
    up_req = 1'b1;
    dn_req = 1'b1;
    tick(10);
    expect_v(4'h0, 16'h0);
    up_req = 1'b0;
    dn_req = 1'b0;
    cmp_a = 1'b1;
    tick(2);
    cmp_a = 1'b0;
    tick(8);
    expect_v(4'h5, 16'h0);
    cmp_a = 1'b1;
    tick(10);
    expect_v(4'h5, 16'h1);
    cmp_a = 1'b0;
    cmp_b = 1'b0;
    tick(10);
    expect_v(4'h5, 16'h1);
    cmp_b = 1'b1;
    tick(10);
    expect_v(4'h5, 16'h0);
    fmask = 1'b1;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    cmd_dn = 1'b1;
    tick(1);
    cmd_dn = 1'b0;
    expect_v(4'h0, 16'h1);
    cmp_a = 1'b1;
    tick(10);
    expect_v(4'h5, 16'h0);
    cmd_rel = 1'b1;
    tick(1);
    cmd_rel = 1'b0;
    expect_v(4'h5, 16'h1);
    cmp_a = 1'b0;
    tick(10);
    expect_v(4'h5, 16'h0);
    d = 8'($urandom);
    naddr = 8'($urandom);
    nwd = d;
    nvm_we = 1'b1;
    tick(1);
    nvm_we = 1'b0;
    tick(2);
    expect_v(4'h6, {8'h0, d});
    wp = 1'b1;
    tick(4);
    nwd = ~d;
    cfg_vh = 1'b0;
    nvm_we = 1'b1;
    cfg_we = 1'b1;
    tick(1);
    nvm_we = 1'b0;
    cfg_we = 1'b0;
    tick(3);
    expect_v(4'h7, 16'h1);
    expect_v(4'h6, {8'h0, d});
    expect_v(4'h4, 16'h1);
    tick(2);
    report_and_stop();
  end
endmodule // supply_margin_trim_monitor_tb_top
